// ### logic/dcc_top.sv
// Dual comparator control: AXI4-Lite registers, result shaping, interrupt flags and wake-up.
// Assumes comparator outputs and port registers are levels that may be sampled at any clock edge.
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module dcc_top import dcc_pkg::*; #(
	parameter int NUM = DCC_NUM
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [DCC_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [DCC_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NUM-1:0] rawCompare,
	input wire logic [NUM-1:0] vectorAck,
	input wire logic [NUM-1:0] portControl,
	input wire logic [NUM-1:0] portData,
	input wire logic sleepMode,
	output logic [NUM-1:0] analogEnable,
	output logic [NUM-1:0] hysteresisOn,
	output logic [NUM-1:0] pullHighDisconnect,
	output logic [NUM-1:0] pinOut,
	output logic [NUM-1:0] pinOutEn,
	output logic [NUM-1:0] pinReadData,
	output logic [NUM-1:0] vectorRequest,
	output logic wakeUp,
	output logic irq
);
	dcc_cfg_t cfg_r [NUM];
	dcc_cfg_t cfg_nxt [NUM];
	logic [NUM-1:0] sync1_r, sync2_r, result_r, result_nxt;
	logic [NUM-1:0] flag_r, flag_nxt, stat_r, stat_nxt, mask_r, mask_nxt;
	logic [NUM-1:0] change;
	dcc_wr_state_t wrState_r, wrState_nxt;
	logic awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt;
	logic [DCC_AW-1:0] awAddr_r, awAddr_nxt;
	logic [31:0] wData_r, wData_nxt;
	logic wStrb0_r, wStrb0_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic doWrite, doRead;

	// Byte view of one control register; unimplemented bits always read zero.
	function automatic logic [7:0] ctrlByte(input dcc_cfg_t c, input logic res);
		logic [7:0] b;
		b = 8'h00;
		b[DCC_BIT_EN] = c.enable;
		b[DCC_BIT_INV] = c.invert;
		b[DCC_BIT_RES] = res;
		b[DCC_BIT_HYS] = c.hysteresis;
		return b;
	endfunction

	function automatic logic isMapped(input logic [DCC_AW-1:0] a);
		return a == DCC_OFS_CTRL0 || a == DCC_OFS_CTRL1 || a == DCC_OFS_STAT ||
			a == DCC_OFS_MASK || a == DCC_OFS_FLAG || a == DCC_OFS_PIN;
	endfunction

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= rawCompare;
			sync2_r <= sync1_r;
		end
	end

	// Write channel: address and data may arrive in either order; response follows both.
	assign s_axi_awready = (wrState_r == DCC_WR_IDLE) && !awHeld_r;
	assign s_axi_wready = (wrState_r == DCC_WR_IDLE) && !wHeld_r;
	assign doWrite = (wrState_r == DCC_WR_IDLE) && (awHeld_r || s_axi_awvalid) && (wHeld_r || s_axi_wvalid);
	assign s_axi_bvalid = (wrState_r == DCC_WR_RESP);
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign doRead = s_axi_arvalid && !rvalid_r;

	logic [DCC_AW-1:0] wAddr;
	logic [31:0] wData;
	logic wStrb0;
	always_comb begin
		wAddr = awHeld_r ? awAddr_r : s_axi_awaddr;
		wData = wHeld_r ? wData_r : s_axi_wdata;
		wStrb0 = wHeld_r ? wStrb0_r : s_axi_wstrb[0];
		wrState_nxt = wrState_r;
		awHeld_nxt = awHeld_r;
		wHeld_nxt = wHeld_r;
		awAddr_nxt = awAddr_r;
		wData_nxt = wData_r;
		wStrb0_nxt = wStrb0_r;
		bresp_nxt = bresp_r;
		case (wrState_r)
			DCC_WR_IDLE: begin
				if (doWrite) begin
					awHeld_nxt = 1'b0;
					wHeld_nxt = 1'b0;
					bresp_nxt = isMapped(wAddr) ? DCC_RESP_OKAY : DCC_RESP_SLVERR;
					wrState_nxt = DCC_WR_RESP;
				end else begin
					if (s_axi_awvalid && !awHeld_r) begin
						awHeld_nxt = 1'b1;
						awAddr_nxt = s_axi_awaddr;
					end
					if (s_axi_wvalid && !wHeld_r) begin
						wHeld_nxt = 1'b1;
						wData_nxt = s_axi_wdata;
						wStrb0_nxt = s_axi_wstrb[0];
					end
				end
			end
			DCC_WR_RESP: begin
				if (s_axi_bready) begin
					wrState_nxt = DCC_WR_IDLE;
				end
			end
			default: wrState_nxt = DCC_WR_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wrState_r <= DCC_WR_IDLE;
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= '0;
			wData_r <= '0;
			wStrb0_r <= 1'b0;
			bresp_r <= DCC_RESP_OKAY;
		end else begin
			wrState_r <= wrState_nxt;
			awHeld_r <= awHeld_nxt;
			wHeld_r <= wHeld_nxt;
			awAddr_r <= awAddr_nxt;
			wData_r <= wData_nxt;
			wStrb0_r <= wStrb0_nxt;
			bresp_r <= bresp_nxt;
		end
	end

	// Configuration, result, flags, status and mask.
	always_comb begin
		for (int i = 0; i < NUM; i++) begin
			cfg_nxt[i] = cfg_r[i];
			result_nxt[i] = cfg_r[i].enable & (sync2_r[i] ^ cfg_r[i].invert);
		end
		// edges of the internal result bit
		change = result_nxt ^ result_r;
		mask_nxt = mask_r;
		flag_nxt = flag_r;
		stat_nxt = stat_r;
		if (doWrite && wStrb0) begin
			for (int i = 0; i < NUM; i++) begin
				if (wAddr == (i == 0 ? DCC_OFS_CTRL0 : DCC_OFS_CTRL1)) begin
					cfg_nxt[i].enable = wData[DCC_BIT_EN];
					cfg_nxt[i].invert = wData[DCC_BIT_INV];
					cfg_nxt[i].hysteresis = wData[DCC_BIT_HYS];
					cfg_nxt[i].intEnable = wData[DCC_BIT_IE];
					cfg_nxt[i].pinOutEnable = wData[DCC_BIT_OE];
				end
			end
			if (wAddr == DCC_OFS_MASK) begin
				mask_nxt = wData[NUM-1:0];
			end
			if (wAddr == DCC_OFS_FLAG) begin
				flag_nxt = wData[NUM-1:0];
			end
		end
		flag_nxt = flag_nxt & ~vectorAck;
		if (doRead && s_axi_araddr == DCC_OFS_STAT) begin
			stat_nxt = '0;
		end
		// set on either edge, winning over any clear
		flag_nxt = flag_nxt | change;
		stat_nxt = stat_nxt | change;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < NUM; i++) begin
				cfg_r[i] <= '{enable: DCC_CTRL_RST[DCC_BIT_EN], invert: DCC_CTRL_RST[DCC_BIT_INV],
					hysteresis: DCC_CTRL_RST[DCC_BIT_HYS], intEnable: 1'b0, pinOutEnable: 1'b0};
			end
			result_r <= '0;
			flag_r <= '0;
			stat_r <= '0;
			mask_r <= '0;
		end else begin
			for (int i = 0; i < NUM; i++) begin
				cfg_r[i] <= cfg_nxt[i];
			end
			result_r <= result_nxt;
			flag_r <= flag_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
		end
	end

	// Read channel: one registered answer a cycle after the address is taken.
	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (doRead) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = isMapped(s_axi_araddr) ? DCC_RESP_OKAY : DCC_RESP_SLVERR;
			rdata_nxt = '0;
			case (s_axi_araddr)
				DCC_OFS_CTRL0: rdata_nxt = {16'h0000, 5'h00, cfg_r[0].pinOutEnable, cfg_r[0].intEnable, 1'b0,
					ctrlByte(cfg_r[0], result_r[0])};
				DCC_OFS_CTRL1: rdata_nxt = {16'h0000, 5'h00, cfg_r[1].pinOutEnable, cfg_r[1].intEnable, 1'b0,
					ctrlByte(cfg_r[1], result_r[1])};
				DCC_OFS_STAT: rdata_nxt[NUM-1:0] = stat_r;
				DCC_OFS_MASK: rdata_nxt[NUM-1:0] = mask_r;
				DCC_OFS_FLAG: rdata_nxt[NUM-1:0] = flag_r;
				DCC_OFS_PIN: rdata_nxt[NUM-1:0] = pinReadData;
				default: rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= DCC_RESP_OKAY;
		end else begin
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// Pin and interrupt side outputs, one comparator per generate slice.
	logic [NUM-1:0] wakeEach;
	for (genvar g = 0; g < NUM; g++) begin : gSlice
		assign analogEnable[g] = cfg_r[g].enable;
		assign hysteresisOn[g] = cfg_r[g].hysteresis;
		assign pullHighDisconnect[g] = cfg_r[g].enable;
		assign pinOut[g] = result_r[g];
		assign pinOutEn[g] = cfg_r[g].enable & cfg_r[g].pinOutEnable;
		assign pinReadData[g] = cfg_r[g].enable ? (portControl[g] ? 1'b0 : portData[g]) : portData[g];
		assign vectorRequest[g] = flag_r[g] & cfg_r[g].intEnable;
		// wake on new flag in sleep
		assign wakeEach[g] = sleepMode & cfg_r[g].enable & change[g] & ~flag_r[g];
	end
	assign wakeUp = |wakeEach;
	assign irq = |(stat_r & mask_r);
endmodule

// ### logic/dcc_pkg.sv
// Constants, register map and carrier types of the dual comparator control block.
// Assumes a 32-bit AXI4-Lite register bus and asynchronous analog comparator outputs.
// Summary of operation
// - Two independent comparators, indexed zero and one.
// - Bit 6 enables comparator, reset zero.
// - Disabled comparator forces result low.
// - Bit 5 inverts result, reset zero.
// - Bit 4 read-only polarity-adjusted compare result.
// - Bit 0 enables hysteresis, reset one.
// - Bits 7 and 3..1 read zero.
// - Enabled comparator disconnects input pull-highs.
// - Result can drive shared output pin.
// - Any result change sets interrupt flag.
// - Flag plus enable requests own vector.
// - Interrupt follows result bit, not pin.
// - New flag from result change wakes core from sleep.
// - Pin data reads zero or port data.
// - Enabled comparator stays active in sleep.
package dcc_pkg;
	localparam int DCC_NUM = 2;
	localparam int DCC_AW = 8;
	localparam logic [7:0] DCC_OFS_CTRL0 = 8'h00;
	localparam logic [7:0] DCC_OFS_CTRL1 = 8'h04;
	localparam logic [7:0] DCC_OFS_STAT = 8'h08;
	localparam logic [7:0] DCC_OFS_MASK = 8'h0C;
	localparam logic [7:0] DCC_OFS_FLAG = 8'h10;
	localparam logic [7:0] DCC_OFS_PIN = 8'h14;
	localparam int DCC_BIT_EN = 6;
	localparam int DCC_BIT_INV = 5;
	localparam int DCC_BIT_RES = 4;
	localparam int DCC_BIT_HYS = 0;
	localparam int DCC_BIT_IE = 9;
	localparam int DCC_BIT_OE = 10;
	localparam logic [7:0] DCC_CTRL_RST = 8'h01;
	localparam logic [7:0] DCC_CTRL_WMASK = 8'h61;
	localparam logic [1:0] DCC_RESP_OKAY = 2'h0;
	localparam logic [1:0] DCC_RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic enable;
		logic invert;
		logic hysteresis;
		logic intEnable;
		logic pinOutEnable;
	} dcc_cfg_t;
	typedef enum logic [1:0] {
		DCC_WR_IDLE = 2'b00,
		DCC_WR_RESP = 2'b01
	} dcc_wr_state_t;
endpackage

// ### dv/dcc_top_sva.sv
// Port-level checker for dcc_top, bound into every instance.
// Assumes three edges from an analog input change to the result register.
`timescale 1ns/1ps
module dcc_top_sva import dcc_pkg::*; #(
	parameter int NUM = DCC_NUM
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [NUM-1:0] rawCompare,
	input wire logic [NUM-1:0] vectorAck,
	input wire logic [NUM-1:0] portControl,
	input wire logic [NUM-1:0] portData,
	input wire logic sleepMode,
	input wire logic [NUM-1:0] analogEnable,
	input wire logic [NUM-1:0] pullHighDisconnect,
	input wire logic [NUM-1:0] pinOut,
	input wire logic [NUM-1:0] pinOutEn,
	input wire logic [NUM-1:0] pinReadData,
	input wire logic [NUM-1:0] vectorRequest,
	input wire logic wakeUp
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);
	chk_pull_off: assert property (pullHighDisconnect == analogEnable)
		else $error("pull-high state wrong");
	chk_off_low: assert property (!(|(~analogEnable & ~$past(analogEnable) & pinOut)))
		else $error("disabled result high");
	chk_pin_read: assert property (pinReadData == (portData & ~(analogEnable & portControl)))
		else $error("pin read value wrong");
	chk_pin_drive: assert property (!(|(pinOutEn & ~analogEnable)))
		else $error("pin driven while off");
	// A write may also move the result, through enable or invert.
	chk_sync_lat: assert property ($changed(pinOut[0]) |-> $past(rawCompare[0], 3) != $past(rawCompare[0], 4)
		|| $past(s_axi_wvalid) || $past(s_axi_wvalid, 2)) else $error("result moved without cause");
	chk_wake_sleep: assert property (wakeUp |-> sleepMode && (|analogEnable))
		else $error("wake outside sleep");
	chk_vec_clear: assert property (vectorAck[0] && !s_axi_wvalid |=> !vectorRequest[0] || $changed(pinOut[0]))
		else $error("vector entry left flag set");
	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
endmodule
bind dcc_top dcc_top_sva #(.NUM(NUM)) u_sva (
	.clk_sys(clk_sys),
	.arst_n(arst_n),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.rawCompare(rawCompare),
	.vectorAck(vectorAck),
	.portControl(portControl),
	.portData(portData),
	.sleepMode(sleepMode),
	.analogEnable(analogEnable),
	.pullHighDisconnect(pullHighDisconnect),
	.pinOut(pinOut),
	.pinOutEn(pinOutEn),
	.pinReadData(pinReadData),
	.vectorRequest(vectorRequest),
	.wakeUp(wakeUp)
);

// ### dv/dcc_analog_model.sv
// Model of the comparator cores, port registers and interrupt controller.
// Assumes the bench sets levels through drive and switches vector entry with ackOn.
`timescale 1ns/1ps
module dcc_analog_model import dcc_pkg::*; (
	input wire logic clk_sys,
	input wire logic [DCC_NUM-1:0] vectorRequest,
	output logic [DCC_NUM-1:0] rawCompare,
	output logic [DCC_NUM-1:0] vectorAck,
	output logic [DCC_NUM-1:0] portControl,
	output logic [DCC_NUM-1:0] portData,
	output logic sleepMode
);
	logic ackOn = 1'b0;
	initial begin
		rawCompare = 2'h0;
		vectorAck = 2'h0;
		portControl = 2'h0;
		portData = 2'h0;
		sleepMode = 1'b0;
	end
	task automatic drive(input logic [1:0] raw, input logic [1:0] pc, input logic [1:0] pd, input logic sl);
		@(posedge clk_sys);
		rawCompare <= raw;
		portControl <= pc;
		portData <= pd;
		sleepMode <= sl;
	endtask
	always @(posedge clk_sys) begin
		vectorAck <= ackOn ? (vectorRequest & ~vectorAck) : 2'h0;
	end
endmodule

// ### dv/tb_top.sv
// Self-checking bench for dcc_top: register sequences over AXI4-Lite.
// Assumes the analog model drives the far side while the bound checker watches the ports.
`timescale 1ns/1ps
module tb_top import dcc_pkg::*;;
	logic clk_sys, a, w;
	logic arst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wakeUp, irq, sleepMode;
	logic [1:0] s_axi_bresp, s_axi_rresp, rawCompare, vectorAck, portControl, portData, analogEnable;
	logic [1:0] hysteresisOn, pullHighDisconnect, pinOut, pinOutEn, pinReadData, vectorRequest;
	int fails, check_count, wakes;
	dcc_top DUT (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.rawCompare(rawCompare),
		.vectorAck(vectorAck),
		.portControl(portControl),
		.portData(portData),
		.sleepMode(sleepMode),
		.analogEnable(analogEnable),
		.hysteresisOn(hysteresisOn),
		.pullHighDisconnect(pullHighDisconnect),
		.pinOut(pinOut),
		.pinOutEn(pinOutEn),
		.pinReadData(pinReadData),
		.vectorRequest(vectorRequest),
		.wakeUp(wakeUp),
		.irq(irq)
	);
	dcc_analog_model PM (
		.clk_sys(clk_sys),
		.vectorRequest(vectorRequest),
		.rawCompare(rawCompare),
		.vectorAck(vectorAck),
		.portControl(portControl),
		.portData(portData),
		.sleepMode(sleepMode)
	);
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) if (wakeUp === 1'b1) wakes++;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk_sys);
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		a = 1'b0;
		w = 1'b0;
		while (!(a && w)) begin
			@(negedge clk_sys);
			a |= s_axi_awready;
			w |= s_axi_wready;
			@(posedge clk_sys);
			s_axi_awvalid <= !a;
			s_axi_wvalid <= !w;
		end
		// A late bready makes the response wait one cycle, so its hold is exercised.
		@(posedge clk_sys);
		s_axi_bready <= 1'b1;
		do @(negedge clk_sys); while (s_axi_bvalid !== 1'b1);
		chk({30'h0, s_axi_bresp}, {30'h0, er});
		@(posedge clk_sys);
		s_axi_bready <= 1'b0;
	endtask
	// Only the low byte is compared; upper bits hold the designer's extra controls.
	task automatic rd(input logic [7:0] ad, input logic [7:0] exp, input logic [1:0] er);
		@(posedge clk_sys);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge clk_sys);
			a = s_axi_arready;
			@(posedge clk_sys);
		end while (a !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(negedge clk_sys); while (s_axi_rvalid !== 1'b1);
		chk({24'h0, s_axi_rdata[7:0]}, {24'h0, exp});
		chk({30'h0, s_axi_rresp}, {30'h0, er});
		@(posedge clk_sys);
		s_axi_rready <= 1'b0;
	endtask
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		#200000;
		fails++;
		finish_test();
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(negedge clk_sys);
		chk({30'h0, hysteresisOn}, 32'h3);
		rd(DCC_OFS_CTRL0, 8'h01, DCC_RESP_OKAY);
		rd(DCC_OFS_CTRL1, 8'h01, DCC_RESP_OKAY);
		wr(DCC_OFS_CTRL0, 32'h8E, DCC_RESP_OKAY);
		rd(DCC_OFS_CTRL0, 8'h00, DCC_RESP_OKAY);
		wr(DCC_OFS_CTRL0, 32'h21, DCC_RESP_OKAY);
		PM.drive(2'h0, 2'h3, 2'h3, 1'b0);
		repeat (5) @(negedge clk_sys);
		chk({30'h0, pinReadData}, 32'h3);
		rd(DCC_OFS_CTRL0, 8'h21, DCC_RESP_OKAY);
		wr(DCC_OFS_CTRL0, 32'h61, DCC_RESP_OKAY);
		repeat (5) @(negedge clk_sys);
		chk({28'h0, pullHighDisconnect, pinReadData}, 32'h6);
		rd(DCC_OFS_CTRL0, 8'h71, DCC_RESP_OKAY);
		wr(DCC_OFS_MASK, 32'h1, DCC_RESP_OKAY);
		@(negedge clk_sys);
		chk({31'h0, irq}, 32'h1);
		rd(DCC_OFS_STAT, 8'h01, DCC_RESP_OKAY);
		rd(DCC_OFS_STAT, 8'h00, DCC_RESP_OKAY);
		@(negedge clk_sys);
		chk({31'h0, irq}, 32'h0);
		PM.drive(2'h1, 2'h3, 2'h3, 1'b0);
		repeat (5) @(negedge clk_sys);
		rd(DCC_OFS_STAT, 8'h01, DCC_RESP_OKAY);
		PM.ackOn <= 1'b1;
		wr(DCC_OFS_CTRL0, 32'h261, DCC_RESP_OKAY);
		repeat (5) @(negedge clk_sys);
		rd(DCC_OFS_FLAG, 8'h00, DCC_RESP_OKAY);
		PM.ackOn <= 1'b0;
		PM.drive(2'h1, 2'h3, 2'h3, 1'b1);
		wr(DCC_OFS_FLAG, 32'h1, DCC_RESP_OKAY);
		@(negedge clk_sys);
		chk({30'h0, vectorRequest}, 32'h1);
		PM.drive(2'h0, 2'h3, 2'h3, 1'b1);
		repeat (5) @(negedge clk_sys);
		chk(wakes, 32'h0);
		wr(DCC_OFS_FLAG, 32'h0, DCC_RESP_OKAY);
		PM.drive(2'h1, 2'h3, 2'h3, 1'b1);
		repeat (5) @(negedge clk_sys);
		chk(wakes, 32'h1);
		rd(DCC_OFS_CTRL0, 8'h61, DCC_RESP_OKAY);
		wr(DCC_OFS_CTRL1, 32'h441, DCC_RESP_OKAY);
		PM.drive(2'h3, 2'h0, 2'h0, 1'b0);
		repeat (5) @(negedge clk_sys);
		chk({28'h0, pinOutEn, pinOut}, 32'hA);
		rd(DCC_OFS_CTRL1, 8'h51, DCC_RESP_OKAY);
		rd(DCC_OFS_CTRL0, 8'h61, DCC_RESP_OKAY);
		wr(DCC_OFS_CTRL1, 32'h401, DCC_RESP_OKAY);
		repeat (2) @(negedge clk_sys);
		chk({28'h0, pinOutEn, pinOut}, 32'h0);
		rd(DCC_OFS_CTRL1, 8'h01, DCC_RESP_OKAY);
		wr(8'h18, 32'hFF, DCC_RESP_SLVERR);
		rd(8'h18, 8'h00, DCC_RESP_SLVERR);
		finish_test();
	end
endmodule
